/* File: core/lpf_defines.vh */
// Register map, field positions, reset values and timing counts of the LED frame player.
`ifndef LPF_DEFINES_VH
`define LPF_DEFINES_VH
`define LPF_ADDR_CONFIG        8'h00
`define LPF_ADDR_LED_HI        8'h01
`define LPF_ADDR_LED_LO        8'h02
`define LPF_ADDR_CUR_GAIN      8'h03
`define LPF_ADDR_CHAN_FUNC     8'h04
`define LPF_ADDR_GPIO_DIR      8'h05
`define LPF_ADDR_GPIO_LEVEL    8'h06
`define LPF_ADDR_GPIO_MASK     8'h07
`define LPF_ADDR_GPIO_STATE    8'h08
`define LPF_ADDR_SAMPLE_DIV    8'h09
`define LPF_ADDR_DUTY_FIRST    8'h10
`define LPF_ADDR_DUTY_LAST     8'h1f
`define LPF_ADDR_FRAME_FIRST   8'h20
`define LPF_ADDR_FRAME_LAST    8'haf
`define LPF_ADDR_DUTY_COMMIT   8'hb0
`define LPF_ADDR_FRAME_IVL     8'hb6
`define LPF_ADDR_FIRST_FRAME   8'hb7
`define LPF_COMMIT_KEY         8'h00
`define LPF_FRAME_BYTES        8'h12
`define LPF_RST_CONFIG         8'h80
`define LPF_RST_LED            8'hff
`define LPF_RST_ZERO           8'h00
`define LPF_CFG_SHUTDOWN_BIT   7
`define LPF_CFG_MODE_HI        6
`define LPF_CFG_MODE_LO        5
`define LPF_CFG_AUDIO_MOD_BIT  4
`define LPF_CG_ROLE_BIT        7
`define LPF_CG_CS_HI           6
`define LPF_CG_CS_LO           4
`define LPF_CG_AGC_BIT         3
`define LPF_CG_GAIN_HI         2
`define LPF_CG_GAIN_LO         0
`define LPF_SEL_HI             7
`define LPF_SEL_LO             5
`define LPF_MODE_DIRECT        2'b00
`define LPF_MODE_AUTO          2'b01
`define LPF_MODE_AUDIO         2'b10
`define LPF_CLK_KHZ            10000
`define LPF_SAMPLE_BASE_KHZ    100
`define LPF_SAMPLE_BASE_CYC    (`LPF_CLK_KHZ / `LPF_SAMPLE_BASE_KHZ)
`define LPF_FRAME_DELAY0_US    4870
`define LPF_FRAME_DELAY1_US    9500
`define LPF_FRAME_DELAY0_CYC   (`LPF_FRAME_DELAY0_US * `LPF_CLK_KHZ / 1000)
`define LPF_FRAME_DELAY1_CYC   (`LPF_FRAME_DELAY1_US * `LPF_CLK_KHZ / 1000)
`define LPF_GAIN_STEP_DB       5'h03
`endif

/* File: core/lpf_frame_player.v */
// Sixteen-channel LED PWM engine with frame memory, GPIO upper channels and cascade timing.
//
// Functional notes
// [RL1] Current scale code picks 1.0, 0.75, 0.5, 0.25, 2.0, 1.75, 1.5, 1.25 times reference.
// [RL2] AGC on when agc_enable_n is 0; gain code gives 0 to 21 dB in 3 dB steps.
// [RL3] Function bit 1 makes an upper pin GPIO; lighting settings then skip it.
// [RL4] Direction bit 0 means output, 1 means input; resets to zero.
// [RL5] GPIO output pin is driven at its output-level bit.
// [RL6] Interrupt mask bit 0 enables change interrupt of an input; reset enables all.
// [RL7] State register holds input levels; change_irq_n stays low until the host reads it.
// [RL8] Audio mode samples input at 100 kHz divided by the divisor register.
// [RL9] Channel average current is full scale times duty over 256.
// [RL10] Duty registers at 10h to 1Fh, channel 16 lowest to channel 1 highest.
// [RL11] Frame memory holds eight 18-byte frames from 20h to AFh.
// [RL12] Duty writes go to shadows; writing 00h to B0h commits them.
// [RL13] Frame interval code gives 4.87 ms, 9.5 ms, then doubling up to 608 ms.
// [RL14] First frame code 000 to 111 selects frame 1 to 8.
// [RL15] Auto play runs from start frame to frame 8, wraps to 1, repeats.
// [RL16] Mode 00 drives all channels from active duty registers.
// [RL17] Host makes breathing by rewriting duties and committing each time.
// [RL18] Host steps duties through a 32 or 64 entry gamma table; the host model's gamma_step uses an 8-entry table.
// [RL19] Enabled input change drives change_irq_n low.
// [RL20] Cascade role 0 drives the cascade clock, role 1 follows it as input.
// [RL21] Mode 00 direct, 01 auto play, 10 audio frame, 11 unavailable.
// [RL22] Audio mode shows frame 1 for smallest level up to frame 8 for largest.
// [RL23] Zero divisor stops sampling and holds the current frame.
// [RL24] Frame memory writes show on next display without commit.
`timescale 1ns/1ps
`include "lpf_defines.vh"

module lpf_frame_player #(
  parameter FRAME_DELAY0_CYC = `LPF_FRAME_DELAY0_CYC,
  parameter FRAME_DELAY1_CYC = `LPF_FRAME_DELAY1_CYC,
  parameter CASC_HALF_CYC    = 4
) (
  // Clock and reset.
  input  wire        ref_clk_in,
  input  wire        sys_rst_in,
  // Register port from the serial target.
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [7:0]  reg_addr_in,
  input  wire [7:0]  reg_wdata_in,
  output reg  [7:0]  reg_rdata_out,
  output reg         reg_rvalid_out,
  // Audio level from the converter.
  input  wire [7:0]  audio_level_in,
  output reg         audio_sample_out,
  output reg         agc_on_out,
  output reg  [4:0]  audio_gain_db_out,
  // Channel drive.
  output reg  [15:0] pwm_out,
  output reg  [3:0]  current_scale_q_out,
  // Upper channel GPIO pins.
  input  wire [7:0]  gpio_in,
  output reg  [7:0]  gpio_out,
  output reg  [7:0]  gpio_oe_out,
  output reg         change_irq_n_out,
  // Cascade clock pin.
  input  wire        casc_clk_in,
  output reg         casc_clk_out,
  output reg         casc_clk_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  reg [7:0]  config_reg;
  reg [7:0]  led_hi_reg;
  reg [7:0]  led_lo_reg;
  reg [7:0]  cur_gain_reg;
  reg [7:0]  chan_func_reg;
  reg [7:0]  gpio_dir_reg;
  reg [7:0]  gpio_level_reg;
  reg [7:0]  gpio_mask_reg;
  reg [7:0]  gpio_state_reg;
  reg [7:0]  sample_div_reg;
  reg [7:0]  frame_ivl_reg;
  reg [7:0]  first_frame_reg;
  reg [7:0]  shadow_reg [0:15];
  reg [7:0]  duty_reg   [0:15];
  reg [7:0]  frame_mem  [0:143];
  reg        irq_pend_reg;
  integer    i;
  integer    sel_idx;
  integer    ch_idx;

  wire [1:0] mode      = config_reg[`LPF_CFG_MODE_HI:`LPF_CFG_MODE_LO];
  wire       shutdown  = config_reg[`LPF_CFG_SHUTDOWN_BIT];
  wire       slave     = cur_gain_reg[`LPF_CG_ROLE_BIT];
  wire [2:0] cs_sel    = cur_gain_reg[`LPF_CG_CS_HI:`LPF_CG_CS_LO];
  wire [7:0] frame_off = reg_addr_in - `LPF_ADDR_FRAME_FIRST;
  wire [3:0] duty_idx  = reg_addr_in[3:0];
  wire       rd_state  = reg_rd_in && (reg_addr_in == `LPF_ADDR_GPIO_STATE);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  reg [7:0] gpio_s1_reg;
  reg [7:0] gpio_s2_reg;
  reg [7:0] gpio_prev_reg;
  reg       casc_s1_reg;
  reg       casc_s2_reg;
  reg       casc_prev_reg;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      gpio_s1_reg   <= 8'h00;
      gpio_s2_reg   <= 8'h00;
      gpio_prev_reg <= 8'h00;
      casc_s1_reg   <= 1'b0;
      casc_s2_reg   <= 1'b0;
      casc_prev_reg <= 1'b0;
    end else begin
      gpio_s1_reg   <= gpio_in;
      gpio_s2_reg   <= gpio_s1_reg;
      gpio_prev_reg <= gpio_s2_reg;
      casc_s1_reg   <= casc_clk_in;
      casc_s2_reg   <= casc_s1_reg;
      casc_prev_reg <= casc_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      config_reg      <= `LPF_RST_CONFIG;
      led_hi_reg      <= `LPF_RST_LED;
      led_lo_reg      <= `LPF_RST_LED;
      cur_gain_reg    <= `LPF_RST_ZERO;
      chan_func_reg   <= `LPF_RST_ZERO;
      gpio_dir_reg    <= `LPF_RST_ZERO;
      gpio_level_reg  <= `LPF_RST_ZERO;
      gpio_mask_reg   <= `LPF_RST_ZERO;
      sample_div_reg  <= `LPF_RST_ZERO;
      frame_ivl_reg   <= `LPF_RST_ZERO;
      first_frame_reg <= `LPF_RST_ZERO;
      for (i = 0; i < 16; i = i + 1) begin
        shadow_reg[i] <= `LPF_RST_ZERO;
        duty_reg[i]   <= `LPF_RST_ZERO;
      end
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `LPF_ADDR_CONFIG:      config_reg      <= reg_wdata_in;
        `LPF_ADDR_LED_HI:      led_hi_reg      <= reg_wdata_in;
        `LPF_ADDR_LED_LO:      led_lo_reg      <= reg_wdata_in;
        `LPF_ADDR_CUR_GAIN:    cur_gain_reg    <= reg_wdata_in;
        `LPF_ADDR_CHAN_FUNC:   chan_func_reg   <= reg_wdata_in;
        `LPF_ADDR_GPIO_DIR:    gpio_dir_reg    <= reg_wdata_in;
        `LPF_ADDR_GPIO_LEVEL:  gpio_level_reg  <= reg_wdata_in;
        `LPF_ADDR_GPIO_MASK:   gpio_mask_reg   <= reg_wdata_in;
        `LPF_ADDR_SAMPLE_DIV:  sample_div_reg  <= reg_wdata_in;
        `LPF_ADDR_FRAME_IVL:   frame_ivl_reg   <= reg_wdata_in;
        `LPF_ADDR_FIRST_FRAME: first_frame_reg <= reg_wdata_in;
        // [RL12] Commit on key.
        `LPF_ADDR_DUTY_COMMIT: begin
          if (reg_wdata_in == `LPF_COMMIT_KEY) begin
            for (i = 0; i < 16; i = i + 1) begin
              duty_reg[i] <= shadow_reg[i];
            end
          end
        end
        default: begin
          // [RL10] Shadow duty bytes.
          if ((reg_addr_in & 8'hf0) == `LPF_ADDR_DUTY_FIRST) begin
            shadow_reg[duty_idx] <= reg_wdata_in;
          end
        end
      endcase
    end
  end

  // Frame memory has no reset; its contents are undefined until the host loads them.
  always @(posedge ref_clk_in) begin
    // [RL11] Frame byte store.
    // [RL24] No commit needed.
    if (reg_wr_in && reg_addr_in >= `LPF_ADDR_FRAME_FIRST && reg_addr_in <= `LPF_ADDR_FRAME_LAST) begin
      frame_mem[frame_off] <= reg_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // GPIO, input state and change interrupt.
  wire [7:0] in_pins   = chan_func_reg & gpio_dir_reg;
  wire [7:0] changed   = (gpio_s2_reg ^ gpio_prev_reg) & in_pins & ~gpio_mask_reg;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      gpio_state_reg   <= 8'h00;
      irq_pend_reg     <= 1'b0;
      gpio_out         <= 8'h00;
      gpio_oe_out      <= 8'h00;
      change_irq_n_out <= 1'b1;
      reg_rdata_out    <= 8'h00;
      reg_rvalid_out   <= 1'b0;
    end else begin
      // [RL7] Capture input levels.
      gpio_state_reg <= gpio_s2_reg & in_pins;
      // [RL19] Change sets pending; set wins over read clear.
      // [RL6] Mask bit 0 enables.
      if (|changed) begin
        irq_pend_reg <= 1'b1;
      end else if (rd_state) begin
        irq_pend_reg <= 1'b0;
      end
      change_irq_n_out <= ~((|changed) | (irq_pend_reg & ~rd_state));
      // [RL4] Direction per pin.
      // [RL5] Output level.
      gpio_oe_out    <= chan_func_reg & ~gpio_dir_reg;
      gpio_out       <= gpio_level_reg;
      reg_rvalid_out <= reg_rd_in;
      reg_rdata_out  <= rd_state ? gpio_state_reg : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cascade timing: the master divides its clock, a slave steps on pin edges.
  reg [7:0] casc_div_reg;
  reg       pwm_tick_reg;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      casc_div_reg    <= 8'h00;
      casc_clk_out    <= 1'b0;
      casc_clk_oe_out <= 1'b0;
      pwm_tick_reg    <= 1'b0;
    end else begin
      // [RL20] Role selects pin direction.
      casc_clk_oe_out <= ~slave;
      if (casc_div_reg == CASC_HALF_CYC[7:0] - 8'h01) begin
        casc_div_reg <= 8'h00;
        casc_clk_out <= ~casc_clk_out;
      end else begin
        casc_div_reg <= casc_div_reg + 8'h01;
      end
      if (slave) begin
        pwm_tick_reg <= casc_s2_reg & ~casc_prev_reg;
      end else begin
        pwm_tick_reg <= ~casc_clk_out && casc_div_reg == CASC_HALF_CYC[7:0] - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencing for auto play and audio modes.
  reg [2:0]  frame_reg;
  reg [23:0] delay_cnt_reg;
  reg [6:0]  base_cnt_reg;
  reg [7:0]  div_cnt_reg;
  reg [1:0]  mode_prev_reg;
  wire [2:0]  frame_delay_sel = frame_ivl_reg[`LPF_SEL_HI:`LPF_SEL_LO];
  wire [23:0] delay_lim = (frame_delay_sel == 3'b000) ? FRAME_DELAY0_CYC[23:0] :
                          (FRAME_DELAY1_CYC[23:0] << (frame_delay_sel - 3'b001));
  wire       base_tick = (base_cnt_reg == `LPF_SAMPLE_BASE_CYC - 1);
  wire       first_wr  = reg_wr_in && reg_addr_in == `LPF_ADDR_FIRST_FRAME;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      frame_reg        <= 3'b000;
      delay_cnt_reg    <= 24'h00_0000;
      base_cnt_reg     <= 7'h00;
      div_cnt_reg      <= 8'h00;
      mode_prev_reg    <= `LPF_MODE_DIRECT;
      audio_sample_out <= 1'b0;
    end else begin
      mode_prev_reg    <= mode;
      audio_sample_out <= 1'b0;
      base_cnt_reg     <= base_tick ? 7'h00 : base_cnt_reg + 7'h01;
      if (mode == `LPF_MODE_AUTO) begin
        // [RL14] Start frame on entry.
        if (mode_prev_reg != `LPF_MODE_AUTO || first_wr) begin
          frame_reg     <= first_wr ? reg_wdata_in[`LPF_SEL_HI:`LPF_SEL_LO]
                                    : first_frame_reg[`LPF_SEL_HI:`LPF_SEL_LO];
          delay_cnt_reg <= 24'h00_0000;
        // [RL13] Interval per code.
        end else if (delay_cnt_reg >= delay_lim - 24'h00_0001) begin
          delay_cnt_reg <= 24'h00_0000;
          // [RL15] Wrap eight to one.
          frame_reg     <= frame_reg + 3'b001;
        end else begin
          delay_cnt_reg <= delay_cnt_reg + 24'h00_0001;
        end
      end else if (mode == `LPF_MODE_AUDIO) begin
        // [RL8] Divide the 100 kHz base.
        // [RL23] Zero divisor holds frame.
        if (base_tick && sample_div_reg != 8'h00) begin
          if (div_cnt_reg >= sample_div_reg - 8'h01) begin
            div_cnt_reg      <= 8'h00;
            audio_sample_out <= 1'b1;
            // [RL22] Level picks frame.
            frame_reg        <= audio_level_in[7:5];
          end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel duty selection and PWM compare.
  reg [7:0]  pwm_cnt_reg;
  reg [7:0]  sel_duty [0:15];
  reg [15:0] sel_on;
  wire [7:0] frame_base = {1'b0, frame_reg, 4'h0} + {4'h0, frame_reg, 1'b0};

  // [RL16] Direct mode source.
  // [RL21] Mode selects source.
  always @* begin
    for (sel_idx = 0; sel_idx < 16; sel_idx = sel_idx + 1) begin
      if (mode == `LPF_MODE_DIRECT) begin
        sel_duty[sel_idx] = duty_reg[15 - sel_idx];
        sel_on[sel_idx]   = (sel_idx < 8) ? led_lo_reg[sel_idx % 8] : led_hi_reg[sel_idx % 8];
      end else if (mode == `LPF_MODE_AUTO || mode == `LPF_MODE_AUDIO) begin
        sel_duty[sel_idx] = frame_mem[frame_base + 8'h02 + 8'h0f - sel_idx[7:0]];
        sel_on[sel_idx]   = (sel_idx < 8) ? frame_mem[frame_base + 8'h01][sel_idx % 8] :
                                            frame_mem[frame_base][sel_idx % 8];
      end else begin
        sel_duty[sel_idx] = 8'h00;
        sel_on[sel_idx]   = 1'b0;
      end
    end
  end

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pwm_cnt_reg         <= 8'h00;
      pwm_out             <= 16'h0000;
      current_scale_q_out <= 4'h4;
      agc_on_out          <= 1'b1;
      audio_gain_db_out   <= 5'h00;
    end else begin
      if (pwm_tick_reg) begin
        pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      end
      for (ch_idx = 0; ch_idx < 16; ch_idx = ch_idx + 1) begin
        // [RL9] On for duty of 256 steps.
        // [RL3] GPIO pins excluded.
        pwm_out[ch_idx] <= ~shutdown && sel_on[ch_idx] && (pwm_cnt_reg < sel_duty[ch_idx]) &&
                           !(ch_idx >= 8 && chan_func_reg[ch_idx % 8]);
      end
      // [RL1] Scale in quarters.
      case (cs_sel)
        3'b000:  current_scale_q_out <= 4'h4;
        3'b001:  current_scale_q_out <= 4'h3;
        3'b010:  current_scale_q_out <= 4'h2;
        3'b011:  current_scale_q_out <= 4'h1;
        3'b100:  current_scale_q_out <= 4'h8;
        3'b101:  current_scale_q_out <= 4'h7;
        3'b110:  current_scale_q_out <= 4'h6;
        default: current_scale_q_out <= 4'h5;
      endcase
      // [RL2] AGC and gain.
      agc_on_out        <= ~cur_gain_reg[`LPF_CG_AGC_BIT];
      audio_gain_db_out <= `LPF_GAIN_STEP_DB * {2'b00, cur_gain_reg[`LPF_CG_GAIN_HI:`LPF_CG_GAIN_LO]};
    end
  end

endmodule // lpf_frame_player

/* File: testbench/lpf_frame_player_assertions.sv */
// Concurrent checks on the LED frame player ports.
`timescale 1ns/1ps
module lpf_frame_player_assertions (
  // Clock and reset.
  input wire       ref_clk_in,
  input wire       sys_rst_in,
  // Register port.
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_rdata_out,
  input wire       reg_rvalid_out,
  // Observed outputs.
  input wire       audio_sample_out,
  input wire [4:0] audio_gain_db_out,
  input wire [3:0] current_scale_q_out,
  input wire [7:0] gpio_out,
  input wire [7:0] gpio_oe_out,
  input wire       change_irq_n_out,
  input wire       casc_clk_out,
  input wire       casc_clk_oe_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_casc_low;
    (!casc_clk_out)[*4] ##1 (casc_clk_out || !casc_clk_oe_out);
  endsequence
  sequence s_casc_high;
    casc_clk_out[*4] ##1 (!casc_clk_out || !casc_clk_oe_out);
  endsequence
  AST_RVALID_LAT: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read valid missing");
  AST_RVALID_CAUSE: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("read valid without read");
  AST_UNMAPPED_ZERO: assert property (reg_rd_in && reg_addr_in != 8'h08 |=> reg_rdata_out == 8'h00)
    else $error("write-only place read nonzero");
  // The low level may only end through a read of the state register.
  AST_IRQ_HOLD: assert property (!change_irq_n_out && !(reg_rd_in && reg_addr_in == 8'h08) |=> !change_irq_n_out)
    else $error("interrupt released without read");
  AST_CASC_LOW: assert property ($fell(casc_clk_out) && casc_clk_oe_out |-> s_casc_low)
    else $error("cascade clock low phase wrong");
  AST_CASC_HIGH: assert property ($rose(casc_clk_out) && casc_clk_oe_out |-> s_casc_high)
    else $error("cascade clock high phase wrong");
  AST_SAMPLE_GAP: assert property (audio_sample_out |=> (!audio_sample_out)[*8])
    else $error("audio samples too close");
  AST_GAIN_STEP: assert property (audio_gain_db_out % 5'd3 == 5'd0 && audio_gain_db_out <= 5'd21)
    else $error("gain not a 3 dB step");
  AST_SCALE_RANGE: assert property (current_scale_q_out != 4'h0 && current_scale_q_out <= 4'h8)
    else $error("current scale out of range");
  AST_OE_AFTER_WRITE: assert property ($changed(gpio_oe_out) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("pin drive changed without write");
  AST_LEVEL_AFTER_WRITE: assert property ($changed(gpio_out) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("pin level changed without write");
  COV_IRQ: cover property ($fell(change_irq_n_out));
endmodule // lpf_frame_player_assertions
bind lpf_frame_player lpf_frame_player_assertions u_chk (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .audio_sample_out(audio_sample_out), .audio_gain_db_out(audio_gain_db_out),
  .current_scale_q_out(current_scale_q_out), .gpio_out(gpio_out), .gpio_oe_out(gpio_oe_out),
  .change_irq_n_out(change_irq_n_out), .casc_clk_out(casc_clk_out), .casc_clk_oe_out(casc_clk_oe_out));

/* File: testbench/lpf_host_model.sv */
// Host controller model issuing register strobes.
`timescale 1ns/1ps
module lpf_host_model (
  // Clock and read return.
  input  wire       clk_in,
  input  wire [7:0] rdata_in,
  // Register strobes.
  output reg        wr_out,
  output reg        rd_out,
  output reg  [7:0] addr_out,
  output reg  [7:0] wdata_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_in);
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge clk_in);
      wr_out = 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a, output [7:0] d);
    begin
      @(negedge clk_in);
      addr_out = a;
      rd_out = 1'b1;
      @(negedge clk_in);
      rd_out = 1'b0;
      d = rdata_in;
    end
  endtask
  task commit;
    begin
      wr_reg(8'hb0, 8'h00);
    end
  endtask
  task gamma_step(input [7:0] a, input [2:0] s);
    reg [7:0] g;
    begin
      case (s)
        3'h0:    g = 8'h00;
        3'h1:    g = 8'h01;
        3'h2:    g = 8'h02;
        3'h3:    g = 8'h04;
        3'h4:    g = 8'h06;
        3'h5:    g = 8'h0a;
        3'h6:    g = 8'h0d;
        default: g = 8'h12;
      endcase
      wr_reg(a, g);
      commit;
    end
  endtask
endmodule // lpf_host_model

/* File: testbench/led_pwm_frame_player_tb_top.sv */
// Self-checking bench for the LED frame player.
`timescale 1ns/1ps
module led_pwm_frame_player_tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  audio_level = 8'h00;
  reg  [7:0]  gpio_pins = 8'h00;
  reg         link_clk = 1'b0;
  wire        wr, rd, rvalid, smp, agc, irq_n, cco, cco_oe;
  wire [7:0]  addr, wdata, rdata, gout, goe;
  wire [4:0]  gain;
  wire [15:0] pwm;
  wire [3:0]  scale;
  integer     num_errors = 0;
  integer     total_checks = 0;
  integer     i, f, n, k;
  reg  [7:0]  rv, last;
  initial forever #50 clk = ~clk;
  // The far chip's clock runs free at an unrelated phase.
  initial begin
    #237;
    forever #400 link_clk = ~link_clk;
  end
  lpf_host_model host (.clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
  lpf_frame_player #(.FRAME_DELAY0_CYC(20), .FRAME_DELAY1_CYC(40)) uut (
    .ref_clk_in(clk), .sys_rst_in(rst), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .audio_level_in(audio_level),
    .audio_sample_out(smp), .agc_on_out(agc), .audio_gain_db_out(gain), .pwm_out(pwm),
    .current_scale_q_out(scale), .gpio_in(gpio_pins), .gpio_out(gout), .gpio_oe_out(goe),
    .change_irq_n_out(irq_n), .casc_clk_in(link_clk), .casc_clk_out(cco), .casc_clk_oe_out(cco_oe));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One full PWM period of 256 ticks of 8 cycles each.
  task count_on(input integer b, output integer c);
    begin
      c = 0;
      repeat (2048) begin
        @(negedge clk);
        c = c + pwm[b];
      end
    end
  endtask
  // Full-duty frames go dark for one tick, so several cycles are merged.
  task seen(output [7:0] v);
    begin
      v = 8'h00;
      repeat (16) begin
        @(negedge clk);
        v = v | pwm[7:0];
      end
    end
  endtask
  task wait_smp(output integer c);
    begin
      c = 0;
      do begin
        @(negedge clk);
        c = c + 1;
      end while (smp !== 1'b1 && c < 1000);
    end
  endtask
  task watch(output integer c);
    begin
      c = 0;
      repeat (400) begin
        @(negedge clk);
        if (pwm[7:0] !== 8'h00 && pwm[7:0] !== last) begin
          last = pwm[7:0];
          check(last, 8'h01 << k);
          k = (k + 1) % 8;
          c = c + 1;
        end
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_lighting;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        host.wr_reg(8'h03, {1'b0, i[2:0], i[0], i[2:0]});
        repeat (2) @(negedge clk);
        check(scale, (i < 4) ? 4 - i : 12 - i);
        check({agc, gain}, {~i[0], 5'd3 * i[4:0]});
      end
      host.wr_reg(8'h03, 8'h00);
    end
  endtask
  task t_direct;
    begin
      host.wr_reg(8'h00, 8'h00);
      host.wr_reg(8'h10, 8'h80);
      host.wr_reg(8'h1f, 8'h04);
      host.wr_reg(8'hb0, 8'h5a);
      count_on(15, n);
      check(n, 0);
      host.commit;
      count_on(15, n);
      check(n, 1024);
      count_on(0, n);
      check(n, 32);
      host.gamma_step(8'h1f, 3'h7);
      count_on(0, n);
      check(n, 144);
      host.wr_reg(8'h03, 8'h80);
      repeat (4) @(negedge clk);
      check(cco_oe, 0);
      count_on(15, n);
      check(n, 1024);
      host.wr_reg(8'h03, 8'h00);
      repeat (4) @(negedge clk);
      check(cco_oe, 1);
    end
  endtask
  task t_gpio;
    begin
      host.wr_reg(8'h04, 8'hff);
      host.wr_reg(8'h05, 8'hf0);
      host.wr_reg(8'h06, 8'h5a);
      repeat (2) @(negedge clk);
      check(goe, 8'h0f);
      check(gout & goe, 8'h0a);
      count_on(15, n);
      check(n, 0);
    end
  endtask
  task t_irq;
    begin
      host.wr_reg(8'h07, 8'he0);
      host.rd_reg(8'h08, rv);
      gpio_pins[7] = 1'b1;
      repeat (8) @(negedge clk);
      check(irq_n, 1);
      gpio_pins[4] = 1'b1;
      repeat (8) @(negedge clk);
      check(irq_n, 0);
      repeat (20) @(negedge clk);
      check(irq_n, 0);
      host.rd_reg(8'h08, rv);
      check(rv, 8'h90);
      @(negedge clk);
      check(irq_n, 1);
      host.rd_reg(8'h0a, rv);
      check(rv, 8'h00);
    end
  endtask
  task t_auto;
    begin
      for (f = 0; f < 8; f = f + 1)
        for (i = 0; i < 18; i = i + 1)
          host.wr_reg(8'h20 + 8'h12 * f[7:0] + i[7:0], (i == 1) ? 8'h01 << f : (i == 0) ? 8'h00 : 8'hff);
      host.wr_reg(8'hb6, 8'h00);
      host.wr_reg(8'hb7, 8'h60);
      host.wr_reg(8'h00, 8'h20);
      repeat (3) @(negedge clk);
      k = 3;
      last = 8'h00;
      watch(n);
      check(n >= 18 && n <= 21, 1);
      host.wr_reg(8'hb6, 8'h20);
      watch(n);
      check(n >= 8 && n <= 12, 1);
    end
  endtask
  task t_audio;
    begin
      audio_level = 8'he0;
      host.wr_reg(8'h09, 8'h02);
      host.wr_reg(8'h00, 8'h40);
      wait_smp(n);
      wait_smp(n);
      check(n, 200);
      repeat (4) @(negedge clk);
      seen(rv);
      check(rv, 8'h80);
      audio_level = 8'h00;
      wait_smp(n);
      repeat (4) @(negedge clk);
      seen(rv);
      check(rv, 8'h01);
      host.wr_reg(8'h09, 8'h00);
      audio_level = 8'he0;
      wait_smp(n);
      check(n, 1000);
      seen(rv);
      check(rv, 8'h01);
      host.wr_reg(8'h00, 8'h60);
      repeat (4) @(negedge clk);
      seen(rv);
      check(rv, 8'h00);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task conclude;
    begin
      if (num_errors == 0 && total_checks > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  initial begin
    #5_000_000;
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_lighting;
    t_direct;
    t_gpio;
    t_irq;
    t_auto;
    t_audio;
    conclude;
  end
endmodule // led_pwm_frame_player_tb_top
